/* File: design/tpr_pkg.sv */
// Package for the trip priority and reset manager.
// Assumes a 125 MHz control clock and classic Wishbone access.
package tpr_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_KHZ = 125000;
	localparam int unsigned RST_SHORT_MS = 1000;
	localparam int unsigned RST_LONG_MS = 10000;
	localparam int unsigned THERM_STOP_MS = 10000;
	localparam int unsigned FLASH_MS = 640;
	localparam int unsigned PLC_FLASH_MS = 10000;
	localparam int unsigned RST_SHORT_CYC = RST_SHORT_MS * CLK_KHZ;
	localparam int unsigned RST_LONG_CYC = RST_LONG_MS * CLK_KHZ;
	localparam int unsigned THERM_STOP_CYC = THERM_STOP_MS * CLK_KHZ;
	localparam int unsigned FLASH_CYC = FLASH_MS * CLK_KHZ;
	localparam int unsigned PLC_FLASH_CYC = PLC_FLASH_MS * CLK_KHZ;

	// ------------------------------------------------------------
	// Register map and values
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_DEFAULTS = 8'h04;
	localparam logic [7:0] ADR_STATUS = 8'h08;
	localparam logic [2:0] PRIO_HW = 3'h1;
	localparam logic [2:0] PRIO_NONRST = 3'h2;
	localparam logic [2:0] PRIO_STORED = 3'h3;
	localparam logic [2:0] PRIO_HIGH = 3'h4;
	localparam logic [2:0] PRIO_NORMAL = 3'h5;
	localparam logic [2:0] PRIO_UV = 3'h6;
	localparam logic [7:0] UV_CODE = 8'h01;
	localparam logic [1:0] STOP_SEL_RST = 2'h0;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CAT_HW, CAT_NONRST, CAT_STORED, CAT_CARD, CAT_G4B,
		CAT_TUNE, CAT_EXT, CAT_NORMAL, CAT_MINOR, CAT_PHASE,
		CAT_THERM, CAT_UV
	} tpr_cat_t;

	typedef enum logic [1:0] {ST_IDLE, ST_STOP, ST_TRIP} tpr_st_t;

	typedef struct packed {
		logic valid;
		tpr_cat_t cat;
		logic [7:0] code;
		logic enc;
	} tpr_trip_t;

	typedef struct packed {
		logic supply_req;
		logic cmd_enable;
		logic output_enable_parameter;
		logic low_voltage_supply_mode;
		logic [1:0] stop_before_trip_select;
	} tpr_ctrl_t;

	typedef struct packed {
		logic supply_lv;
		logic armed;
		logic stopping;
		logic run_inhibit;
		logic undervoltage_condition_flag;
		logic [7:0] code;
		tpr_cat_t cat;
		logic [2:0] prio;
		logic tripped;
	} tpr_status_t;

endpackage

/* File: design/tpr_trip_manager.sv */
// Trip priority and reset manager with a Wishbone register slave.
// Assumes trip detectors, supply monitors and operator inputs are
// synchronous to clk_i; reset_req_i and trip_i.valid are pulses.
//
// Functional notes
// [RULE1] Hardware faults unresettable, relay open, serial off
// [RULE2] Slot and priority 2 trips ignore resets
// [RULE3] Stored-data fault reset needs defaults code first
// [RULE4] Card trips priority 4, 5 at power-up
// [RULE5] Second group overrides encoder priority 5 only
// [RULE6] After autotune reset, run needs a disable
// [RULE7] Overcurrent trips resettable after ten seconds
// [RULE8] Uncategorised trips: priority 5, one second delay
// [RULE9] Minor trips stop first when select bit 0
// [RULE10] Phase loss stops motor before tripping
// [RULE11] Thermal overheat stops, trips after ten seconds
// [RULE12] Undervoltage priority 6, self clearing, no reset
// [RULE13] Undervoltage blocks output stage enable
// [RULE14] Undervoltage saves parameters unless low-voltage mode
// [RULE15] Undervoltage clears above restart if still active
// [RULE16] Supply switchover only in undervoltage condition
// [RULE17] Undervoltage shown only without other trip
// [RULE18] Power-up undervoltage trip without parameter save
// [RULE19] Alarms flash every 640 ms, PLC every 10 s
// [RULE20] No alarm display while editing a parameter
// [RULE21] New trip only if idle or more important
// [RULE22] Early reset requests leave trip active
//
// Implementation choices: the register offsets and register access over Wishbone.
module tpr_trip_manager #(
	parameter int unsigned RST_SHORT = tpr_pkg::RST_SHORT_CYC,
	parameter int unsigned RST_LONG = tpr_pkg::RST_LONG_CYC,
	parameter int unsigned THERM_STOP = tpr_pkg::THERM_STOP_CYC,
	parameter int unsigned FLASH = tpr_pkg::FLASH_CYC,
	parameter int unsigned PLC_FLASH = tpr_pkg::PLC_FLASH_CYC,
	// Arbitrary value, no documented code
	parameter logic [15:0] DEFAULTS_CODE = 16'h1234
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire tpr_pkg::tpr_trip_t trip_i,
	input wire logic powerup_i,
	input wire logic reset_req_i,
	input wire logic bus_below_uv_i,
	input wire logic bus_above_restart_i,
	input wire logic motor_stopped_i,
	input wire logic safe_torque_off_i,
	input wire logic alarm_i,
	input wire logic plc_alarm_i,
	input wire logic edit_active_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic tripped_o,
	output logic [7:0] trip_code_o,
	output logic drive_healthy_o,
	output logic serial_enable_o,
	output logic output_enable_o,
	output logic stop_request_o,
	output logic pd_save_o,
	output logic supply_lv_o,
	output logic alarm_show_o
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		tpr_pkg::tpr_st_t st;
		tpr_pkg::tpr_cat_t cat;
		logic [2:0] prio;
		logic [7:0] code;
		logic enc;
		logic [31:0] age;
		tpr_pkg::tpr_cat_t pcat;
		logic [7:0] pcode;
		logic [31:0] stop_cnt;
		logic run_inh;
		logic armed;
		logic uv_flag;
		logic init;
		logic pd_save;
		logic supply_lv;
		tpr_pkg::tpr_ctrl_t ctrl;
		logic [31:0] flash_cnt;
		logic show;
		logic ack;
		logic [31:0] dat;
		logic healthy;
		logic out_en;
		logic trip_q;
		logic stop_q;
	} tpr_state_t;

	tpr_state_t s_reg;
	tpr_state_t s_next;

	localparam logic [31:0] AGE_MAX = 32'hFFFFFFFF;

	// Rank of a category; card trips drop a level while powering up
	function automatic logic [2:0] prio_of(tpr_pkg::tpr_cat_t c,
		logic pu);
		case (c)
			tpr_pkg::CAT_HW: prio_of = tpr_pkg::PRIO_HW; // [RULE1]
			tpr_pkg::CAT_NONRST: prio_of = tpr_pkg::PRIO_NONRST;
			tpr_pkg::CAT_STORED: prio_of = tpr_pkg::PRIO_STORED;
			tpr_pkg::CAT_CARD: prio_of = pu ? tpr_pkg::PRIO_NORMAL :
				tpr_pkg::PRIO_HIGH; // [RULE4]
			tpr_pkg::CAT_G4B: prio_of = tpr_pkg::PRIO_HIGH;
			tpr_pkg::CAT_UV: prio_of = tpr_pkg::PRIO_UV; // [RULE12]
			default: prio_of = tpr_pkg::PRIO_NORMAL; // [RULE8]
		endcase
	endfunction

	// Reset gate per category; unresettable ones never pass
	function automatic logic may_reset(tpr_state_t s);
		case (s.cat)
			tpr_pkg::CAT_HW: may_reset = 1'b0; // [RULE1]
			tpr_pkg::CAT_NONRST: may_reset = 1'b0; // [RULE2]
			tpr_pkg::CAT_UV: may_reset = 1'b0; // [RULE12]
			tpr_pkg::CAT_STORED: may_reset = s.armed; // [RULE3]
			tpr_pkg::CAT_EXT: may_reset = s.age >= RST_LONG; // [RULE7]
			default: may_reset = s.age >= RST_SHORT; // [RULE22]
		endcase
	endfunction

	logic [2:0] new_prio;
	logic accept;
	logic stop_first;
	logic wb_req;
	logic arm_set;
	logic disabled;
	logic [31:0] period;

	// ------------------------------------------------------------
	// Trip arbitration terms
	// ------------------------------------------------------------
	always_comb begin
		new_prio = prio_of(trip_i.cat, powerup_i);
		accept = 1'b0;
		if (trip_i.valid) begin
			if (s_reg.st != tpr_pkg::ST_TRIP) begin
				accept = 1'b1; // [RULE21]
			end else if (new_prio < s_reg.prio) begin
				accept = 1'b1; // [RULE21]
				// Second group beats a priority 5 trip only if encoder
				if (trip_i.cat == tpr_pkg::CAT_G4B &&
					s_reg.prio == tpr_pkg::PRIO_NORMAL && !s_reg.enc) begin
					accept = 1'b0; // [RULE5]
				end
			end
		end
		stop_first = (trip_i.cat == tpr_pkg::CAT_MINOR &&
			s_reg.ctrl.stop_before_trip_select[0]) || // [RULE9]
			trip_i.cat == tpr_pkg::CAT_PHASE || // [RULE10]
			trip_i.cat == tpr_pkg::CAT_THERM; // [RULE11]
		wb_req = wb_cyc_i && wb_stb_i && !s_reg.ack;
		// Valid defaults code on both low byte lanes arms the reset
		arm_set = wb_req && wb_we_i && wb_adr_i == tpr_pkg::ADR_DEFAULTS &&
			wb_sel_i[1] && wb_sel_i[0] && wb_dat_i[15:0] == DEFAULTS_CODE;
		disabled = safe_torque_off_i ||
			!s_reg.ctrl.output_enable_parameter || !s_reg.ctrl.cmd_enable;
		period = plc_alarm_i ? PLC_FLASH : FLASH;
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.pd_save = 1'b0;
		s_next.ack = wb_req;
		// Bus writes; byte lane 0 holds control, lanes 0-1 the code
		if (wb_req && wb_we_i) begin
			if (wb_adr_i == tpr_pkg::ADR_CTRL && wb_sel_i[0]) begin
				s_next.ctrl = wb_dat_i[$bits(tpr_pkg::tpr_ctrl_t)-1:0];
			end
			if (arm_set) begin
				s_next.armed = 1'b1; // [RULE3]
			end
		end
		// Undervoltage condition follows the bus monitor
		if (bus_below_uv_i) begin
			s_next.uv_flag = 1'b1;
		end else if (bus_above_restart_i) begin
			s_next.uv_flag = 1'b0;
		end
		// Switchover is latched only in the undervoltage condition
		if (s_reg.uv_flag) begin
			s_next.supply_lv = s_reg.ctrl.supply_req; // [RULE16]
		end
		// Age since the trip occurred saturates
		if (s_reg.st == tpr_pkg::ST_TRIP && s_reg.age != AGE_MAX) begin
			s_next.age = s_reg.age + 32'h00000001;
		end
		// Autotune lock-out is released by any disable path
		if (disabled) begin
			s_next.run_inh = 1'b0; // [RULE6]
		end
		case (s_reg.st)
			tpr_pkg::ST_IDLE: begin
				if (!s_reg.init) begin
					s_next.init = 1'b1;
					if (!bus_above_restart_i && !accept) begin
						s_next.uv_flag = 1'b1;
						s_next.st = tpr_pkg::ST_TRIP; // [RULE18]
						s_next.cat = tpr_pkg::CAT_UV;
						s_next.prio = tpr_pkg::PRIO_UV;
						s_next.code = tpr_pkg::UV_CODE;
						s_next.age = 32'h00000000;
					end
				end else if (s_next.uv_flag && !s_reg.uv_flag &&
					!accept) begin
					s_next.st = tpr_pkg::ST_TRIP; // [RULE17]
					s_next.cat = tpr_pkg::CAT_UV;
					s_next.prio = tpr_pkg::PRIO_UV;
					s_next.code = tpr_pkg::UV_CODE;
					s_next.age = 32'h00000000;
					// Low-voltage supply has no energy for the save
					s_next.pd_save =
						!s_reg.ctrl.low_voltage_supply_mode; // [RULE14]
				end
			end
			tpr_pkg::ST_STOP: begin
				s_next.stop_cnt = s_reg.stop_cnt + 32'h00000001;
				if (motor_stopped_i || (s_reg.pcat == tpr_pkg::CAT_THERM &&
					s_reg.stop_cnt >= THERM_STOP - 1)) begin
					s_next.st = tpr_pkg::ST_TRIP; // [RULE11]
					s_next.cat = s_reg.pcat;
					s_next.prio = tpr_pkg::PRIO_NORMAL;
					s_next.code = s_reg.pcode;
					s_next.enc = 1'b0;
					s_next.age = 32'h00000000;
				end
			end
			tpr_pkg::ST_TRIP: begin
				if (s_reg.cat == tpr_pkg::CAT_UV && bus_above_restart_i) begin
					s_next.st = tpr_pkg::ST_IDLE; // [RULE15]
				end else if (reset_req_i && may_reset(s_reg)) begin
					s_next.st = tpr_pkg::ST_IDLE; // [RULE22]
					if (s_reg.cat == tpr_pkg::CAT_TUNE) begin
						s_next.run_inh = 1'b1; // [RULE6]
					end
					// A fresh code written in the same cycle wins
					if (s_reg.cat == tpr_pkg::CAT_STORED) begin
						s_next.armed = arm_set;
					end
				end
			end
			default: s_next.st = tpr_pkg::ST_IDLE;
		endcase
		// A new trip wins over a reset or clear in the same cycle
		if (accept) begin
			if (s_reg.st == tpr_pkg::ST_IDLE && stop_first) begin
				s_next.st = tpr_pkg::ST_STOP; // [RULE9]
				s_next.pcat = trip_i.cat;
				s_next.pcode = trip_i.code;
				s_next.stop_cnt = 32'h00000000;
			end else if (s_reg.st != tpr_pkg::ST_STOP || !stop_first) begin
				s_next.st = tpr_pkg::ST_TRIP; // [RULE21]
				s_next.cat = trip_i.cat;
				s_next.prio = new_prio;
				s_next.code = trip_i.code;
				s_next.enc = trip_i.enc;
				s_next.age = 32'h00000000;
			end
		end
		// Outputs registered from the next state
		s_next.healthy = !(s_next.st == tpr_pkg::ST_TRIP &&
			s_next.cat == tpr_pkg::CAT_HW); // [RULE1]
		s_next.trip_q = s_next.st == tpr_pkg::ST_TRIP;
		s_next.stop_q = s_next.st == tpr_pkg::ST_STOP;
		s_next.out_en = s_next.st != tpr_pkg::ST_TRIP &&
			!s_next.uv_flag && !s_next.run_inh && // [RULE13]
			!disabled;
		// Alarm flash: on for half of 640 ms in each period
		if (alarm_i) begin
			if (s_reg.flash_cnt >= period - 1) begin
				s_next.flash_cnt = 32'h00000000;
			end else begin
				s_next.flash_cnt = s_reg.flash_cnt + 32'h00000001;
			end
		end else begin
			s_next.flash_cnt = 32'h00000000;
		end
		s_next.show = alarm_i && !edit_active_i && // [RULE20]
			s_next.flash_cnt < FLASH / 2; // [RULE19]
		// Read data; unmapped addresses answer zero
		s_next.dat = 32'h00000000;
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				tpr_pkg::ADR_CTRL: s_next.dat = 32'(s_reg.ctrl);
				tpr_pkg::ADR_DEFAULTS: s_next.dat = 32'(s_reg.armed);
				tpr_pkg::ADR_STATUS: s_next.dat = 32'(tpr_pkg::tpr_status_t'{
					supply_lv: s_reg.supply_lv,
					armed: s_reg.armed,
					stopping: s_reg.st == tpr_pkg::ST_STOP,
					run_inhibit: s_reg.run_inh,
					undervoltage_condition_flag: s_reg.uv_flag,
					code: s_reg.code,
					cat: s_reg.cat,
					prio: s_reg.prio,
					tripped: s_reg.st == tpr_pkg::ST_TRIP});
				default: s_next.dat = 32'h00000000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register; ce_i low freezes everything
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
			s_reg.st <= tpr_pkg::ST_IDLE;
			s_reg.cat <= tpr_pkg::CAT_NORMAL;
			s_reg.pcat <= tpr_pkg::CAT_NORMAL;
			s_reg.ctrl.stop_before_trip_select <= tpr_pkg::STOP_SEL_RST;
			s_reg.healthy <= 1'b1;
		end else if (ce_i) begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_dat_o = s_reg.dat;
	assign wb_ack_o = s_reg.ack;
	assign tripped_o = s_reg.trip_q;
	assign trip_code_o = s_reg.code;
	assign drive_healthy_o = s_reg.healthy;
	assign serial_enable_o = s_reg.healthy; // Comms die with the relay
	assign output_enable_o = s_reg.out_en;
	assign stop_request_o = s_reg.stop_q;
	assign pd_save_o = s_reg.pd_save;
	assign supply_lv_o = s_reg.supply_lv;
	assign alarm_show_o = s_reg.show;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_hw_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		tripped_o && s_reg.cat == tpr_pkg::CAT_HW |=>
		tripped_o && !drive_healthy_o && !serial_enable_o) // [RULE1]
		else $error("hardware fault left or relay closed");
	a_nonrst_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		tripped_o && s_reg.cat == tpr_pkg::CAT_NONRST |=>
		tripped_o) // [RULE2]
		else $error("non-resettable trip cleared");
	a_stored_arm: assert property (@(posedge clk_i) disable iff (rst_i)
		tripped_o && s_reg.cat == tpr_pkg::CAT_STORED && !s_reg.armed
		&& !(wb_req && wb_we_i) |=> tripped_o) // [RULE3]
		else $error("stored-data fault reset without code");
	a_short_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		tripped_o && s_reg.cat == tpr_pkg::CAT_NORMAL &&
		s_reg.age < RST_SHORT |=> tripped_o) // [RULE22]
		else $error("normal trip reset too early");
	a_long_delay: assert property (@(posedge clk_i) disable iff (rst_i)
		tripped_o && s_reg.cat == tpr_pkg::CAT_EXT &&
		s_reg.age < RST_LONG |=> tripped_o) // [RULE7]
		else $error("overcurrent trip reset too early");
	a_uv_no_user: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && tripped_o && s_reg.cat == tpr_pkg::CAT_UV &&
		!bus_above_restart_i && !trip_i.valid |=> tripped_o &&
		s_reg.cat == tpr_pkg::CAT_UV) // [RULE12]
		else $error("undervoltage trip cleared by user");
	a_uv_outen: assert property (@(posedge clk_i) disable iff (rst_i)
		(tripped_o || s_reg.uv_flag) |-> !output_enable_o) // [RULE13]
		else $error("output enabled while tripped");
	a_switch_uv: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(supply_lv_o) |-> $past(s_reg.uv_flag)) // [RULE16]
		else $error("supply switched outside undervoltage");
	a_edit_hide: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && edit_active_i |=> !alarm_show_o) // [RULE20]
		else $error("alarm shown during edit");
	a_save_lv: assert property (@(posedge clk_i) disable iff (rst_i)
		pd_save_o |-> !$past(s_reg.ctrl.low_voltage_supply_mode) &&
		tripped_o && s_reg.cat == tpr_pkg::CAT_UV) // [RULE14]
		else $error("power-down save in low-voltage mode");
	a_g4b_block: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && tripped_o && s_reg.prio == tpr_pkg::PRIO_NORMAL &&
		!s_reg.enc && trip_i.valid && trip_i.cat == tpr_pkg::CAT_G4B
		|=> s_reg.prio == tpr_pkg::PRIO_NORMAL) // [RULE5]
		else $error("group two trip overrode non-encoder trip");

endmodule

/* File: verification/tpr_operator_model.sv */
// Operator side model: reset push-button and second-row display watch.
// Assumes the manager's clock; the button changes just after an edge.
module tpr_operator_model (
	input wire logic clk_i,
	input wire logic alarm_show_i,
	output logic reset_req_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int shown;

	// ------------------------------------------------------------
	// Push-button
	// ------------------------------------------------------------
	initial begin
		reset_req_o = 1'b0;
		shown = 0;
	end

	// One-cycle press; a held button would retry on every cycle
	task automatic press();
		@(posedge clk_i);
		reset_req_o <= 1'b1;
		@(posedge clk_i);
		reset_req_o <= 1'b0;
	endtask

	// Display: count cycles with the alarm on the second row
	always @(posedge clk_i) begin
		if (alarm_show_i === 1'b1) begin
			shown <= shown + 1;
		end
	end
endmodule

/* File: verification/trip_priority_reset_manager_test.sv */
// Self-checking bench for the trip priority and reset manager.
// Assumes short timing parameters; the operator model presses reset.
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin \
	n_errors++; $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
	end end
module trip_priority_reset_manager_test;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SHORT = 20;
	logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, powerup_i = 1'b0;
	tpr_pkg::tpr_trip_t trip_i = '0;
	logic bus_below_uv_i = 1'b0, bus_above_restart_i = 1'b0;
	logic motor_stopped_i = 1'b0, safe_torque_off_i = 1'b0;
	logic alarm_i = 1'b0, plc_alarm_i = 1'b0, edit_active_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata;
	logic wb_ack_o, tripped_o, drive_healthy_o, serial_enable_o;
	logic output_enable_o, stop_request_o, pd_save_o, supply_lv_o;
	logic alarm_show_o, reset_req_i;
	logic [7:0] trip_code_o;
	int n_errors = 0, tests_run = 0, pd_n = 0, a;

	always #4 clk_i = ~clk_i;
	always @(posedge clk_i) if (pd_save_o === 1'b1) pd_n++;

	tpr_trip_manager #(.RST_SHORT(SHORT), .RST_LONG(50), .THERM_STOP(30),
		.FLASH(8), .PLC_FLASH(40)) dut_u (.clk_i, .rst_i, .ce_i, .trip_i,
		.powerup_i, .reset_req_i, .bus_below_uv_i, .bus_above_restart_i,
		.motor_stopped_i, .safe_torque_off_i, .alarm_i, .plc_alarm_i,
		.edit_active_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .tripped_o, .trip_code_o,
		.drive_healthy_o, .serial_enable_o, .output_enable_o, .stop_request_o,
		.pd_save_o, .supply_lv_o, .alarm_show_o);
	tpr_operator_model op_u (.clk_i, .alarm_show_i(alarm_show_o),
		.reset_req_o(reset_req_i));

	// ------------------------------------------------------------
	// Bus and stimulus tasks
	// ------------------------------------------------------------
	// Hold the request until ack is sampled; take data at that edge
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] wd);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'hF;
		wb_dat_i <= wd;
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		rdata = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic at(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic trip(input tpr_pkg::tpr_cat_t c, input logic [7:0] cd,
		input logic e);
		@(posedge clk_i);
		trip_i <= {1'b1, c, cd, e};
		@(posedge clk_i);
		trip_i.valid <= 1'b0;
		at(1);
	endtask

	// Press reset after n cycles, then look at the trip state
	task automatic rst_try(input int n, input logic exp);
		repeat (n) @(posedge clk_i);
		op_u.press();
		at(1);
		`CHK("tripped", exp, tripped_o)
	endtask

	task automatic uv(input logic on);
		@(posedge clk_i);
		bus_below_uv_i <= on;
		bus_above_restart_i <= ~on;
		at(3);
	endtask

	task automatic restart();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (20) @(posedge clk_i);
		at(1);
		`CHK("healthy", 1'b1, drive_healthy_o)
		`CHK("serial", 1'b1, serial_enable_o)
		`CHK("tripped", 1'b0, tripped_o)
		@(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		restart();
		at(3);
		`CHK("pwrup uv", 8'h01, trip_code_o)
		`CHK("pwrup save", 0, pd_n)
		rst_try(2, 1'b1);
		uv(1'b0);
		`CHK("uv cleared", 1'b0, tripped_o)
		wb(1'b0, tpr_pkg::ADR_CTRL, 32'h0);
		`CHK("ctrl reset", 32'h0, rdata)
		wb(1'b1, tpr_pkg::ADR_CTRL, 32'h18);
		wb(1'b1, 8'h0C, 32'hFF);
		wb(1'b0, 8'h0C, 32'h0);
		`CHK("unmapped", 32'h0, rdata)
		wb(1'b0, tpr_pkg::ADR_CTRL, 32'h0);
		`CHK("ctrl", 32'h18, rdata)
		at(2);
		`CHK("enable", 1'b1, output_enable_o)
		trip(tpr_pkg::CAT_NORMAL, 8'h20, 1'b0);
		`CHK("code", 8'h20, trip_code_o)
		trip(tpr_pkg::CAT_STORED, 8'h1F, 1'b0);
		`CHK("replace", 8'h1F, trip_code_o)
		trip(tpr_pkg::CAT_NORMAL, 8'h21, 1'b0);
		`CHK("no replace", 8'h1F, trip_code_o)
		rst_try(SHORT + 5, 1'b1);
		wb(1'b1, tpr_pkg::ADR_DEFAULTS, 32'h1234);
		wb(1'b0, tpr_pkg::ADR_DEFAULTS, 32'h0);
		`CHK("armed", 1'b1, rdata[0])
		rst_try(0, 1'b0);
		trip(tpr_pkg::CAT_MINOR, 8'h22, 1'b0);
		rst_try(3, 1'b1);
		rst_try(SHORT, 1'b0);
		trip(tpr_pkg::CAT_EXT, 8'h03, 1'b0);
		rst_try(30, 1'b1);
		rst_try(25, 1'b0);
		for (int i = 0; i < 4; i++) begin
			powerup_i <= (i == 1);
			if (i < 2) trip(tpr_pkg::CAT_CARD, 8'hB2, 1'b0);
			else trip(tpr_pkg::CAT_NORMAL, 8'h30, i == 3);
			if (i > 1) trip(tpr_pkg::CAT_G4B, 8'h31, 1'b0);
			wb(1'b0, tpr_pkg::ADR_STATUS, 32'h0);
			`CHK("prio", (i == 2) ? 3'h5 : 3'h4 + (i == 1),
				rdata[3:1])
			rst_try(SHORT + 3, 1'b0);
		end
		trip(tpr_pkg::CAT_TUNE, 8'h12, 1'b0);
		rst_try(SHORT + 3, 1'b0);
		at(2);
		`CHK("locked", 1'b0, output_enable_o)
		wb(1'b1, tpr_pkg::ADR_CTRL, 32'h11);
		wb(1'b1, tpr_pkg::ADR_CTRL, 32'h19);
		at(2);
		`CHK("unlocked", 1'b1, output_enable_o)
		for (int i = 0; i < 3; i++) begin
			trip(i == 0 ? tpr_pkg::CAT_MINOR : i == 1 ? tpr_pkg::CAT_PHASE :
				tpr_pkg::CAT_THERM, 8'h40, 1'b0);
			at(2);
			`CHK("stopping", 1'b1, stop_request_o)
			`CHK("not yet", 1'b0, tripped_o)
			motor_stopped_i <= (i < 2);
			at(i < 2 ? 3 : 32);
			motor_stopped_i <= 1'b0;
			`CHK("tripped", 1'b1, tripped_o)
			rst_try(SHORT + 3, 1'b0);
		end
		wb(1'b1, tpr_pkg::ADR_CTRL, 32'h38);
		at(2);
		`CHK("no switch", 1'b0, supply_lv_o)
		uv(1'b1);
		`CHK("uv", 8'h01, trip_code_o)
		`CHK("save", 1, pd_n)
		`CHK("blocked", 1'b0, output_enable_o)
		rst_try(SHORT + 3, 1'b1);
		wb(1'b1, tpr_pkg::ADR_CTRL, 32'h3C);
		at(2);
		`CHK("switch", 1'b1, supply_lv_o)
		uv(1'b0);
		uv(1'b1);
		`CHK("lv no save", 1, pd_n)
		uv(1'b0);
		trip(tpr_pkg::CAT_NORMAL, 8'h50, 1'b0);
		uv(1'b1);
		`CHK("uv hidden", 8'h50, trip_code_o)
		uv(1'b0);
		`CHK("kept", 1'b1, tripped_o)
		rst_try(SHORT, 1'b0);
		alarm_i <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			plc_alarm_i <= (i == 1);
			edit_active_i <= (i == 2);
			at(40);
			a = op_u.shown;
			at(80);
			`CHK("shown", i == 0 ? 40 : i == 1 ? 8 : 0,
				op_u.shown - a)
		end
		for (int i = 0; i < 2; i++) begin
			trip(i ? tpr_pkg::CAT_NONRST : tpr_pkg::CAT_HW, 8'hD9, 1'b0);
			`CHK("healthy", i[0], drive_healthy_o)
			`CHK("serial", i[0], serial_enable_o)
			rst_try(SHORT * 3, 1'b1);
			restart();
		end
		test_done();
	end

	// Watchdog well beyond the roughly 1100 cycles the scenarios need
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		test_done();
	end
endmodule
